// [tra_averager.v]
`include "tra_map.vh"

// Overview of operation
// R1 - rising trigger captures sample into average
// R2 - controller supplies window length input
// R3 - one-time: stop at window, set complete
// R4 - one-time average within half a unit
// R5 - continuous: sliding window keeps updating
// R6 - continuous: recursive approximation, no sample store
// R7 - continuous: complete set at window, stays
// R8 - intermediate average shown while filling
// R9 - count and average outputs always driven
// R10 - triggers only while enabled, if evaluated
// R11 - clear forces count, average, complete zero
// R12 - controller avoids very large window lengths
// R13 - range error on out-of-range window
// R14 - one-time mode after reset
// R15 - signed sample/average, unsigned count/window
// R16 - average plus difference over window
module tra_averager #(
    parameter DATA_W = 32
) (
    input  wire                     ref_clk,
    input  wire                     rst,
    // controller side
    input  wire                     sample_trigger,
    input  wire signed [DATA_W-1:0] sample_value_in,
    input  wire        [DATA_W-1:0] window_length_in,
    input  wire                     enable_in,
    input  wire                     clear_request,
    output wire signed [DATA_W-1:0] average_out,
    output wire        [DATA_W-1:0] sample_count_out,
    output wire                     average_complete,
    output wire                     range_error,
    // avalon-mm slave
    input  wire [4:0]               avs_address,
    input  wire                     avs_read,
    input  wire                     avs_write,
    input  wire [31:0]              avs_writedata,
    input  wire [3:0]               avs_byteenable,
    output wire [31:0]              avs_readdata,
    output wire                     avs_waitrequest
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    // register state
    reg                      mode_cont_q;
    reg                      en_eval_q;
    reg                      ack_q;
    reg  [31:0]              rdata_q;
    reg  signed [63:0]       sum_q;
    reg  [DATA_W-1:0]        count_q;
    reg  signed [DATA_W-1:0] avg_q;
    reg                      done_q;
    reg                      rerr_q;
    reg                      fill_op_q;
    reg                      pend_q;
    reg  signed [DATA_W-1:0] pend_val_q;

    // datapath nets
    wire                     enabled;
    wire                     trig_pulse;
    wire                     div_busy;
    wire                     div_done;
    wire signed [31:0]       div_quot;
    wire                     blocked;
    wire                     take_now;
    wire                     go;
    wire signed [DATA_W-1:0] x_sel;
    wire                     filling;
    wire [DATA_W-1:0]        win_div;
    reg  signed [63:0]       div_num;
    reg  [31:0]              div_den;
    reg  signed [63:0]       new_sum;
    wire                     bus_req;
    wire                     bus_wr_take;
    wire                     ctrl_wr;
    wire                     div_idle;
    wire                     win_bad;

    // sign-extend a sample-width value to the 64-bit accumulator width
    function [63:0] sext64;
        input [DATA_W-1:0] v;
        begin
            sext64 = {{(64-DATA_W){v[DATA_W-1]}}, v};
        end
    endfunction

    // status word assembled from the block's own state
    function [31:0] status_word;
        input done;
        input rerr;
        input busy;
        input pend;
        begin
            status_word                     = 32'h00000000;
            status_word[`TRA_STAT_DONE_BIT] = done;
            status_word[`TRA_STAT_RERR_BIT] = rerr;
            status_word[`TRA_STAT_BUSY_BIT] = busy;
            status_word[`TRA_STAT_PEND_BIT] = pend;
        end
    endfunction

    // ----------------------------------------------------------------
    // avalon-mm slave, one wait state on every access
    // ----------------------------------------------------------------
    assign bus_req         = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~ack_q;
    // map: 0x00 control (bit 0 continuous, bit 1 enable evaluation),
    // 0x04 status (complete, range error, busy, held trigger),
    // 0x08 average, 0x0C sample count; writes outside control
    // are dropped and unmapped reads return zero
    assign bus_wr_take     = avs_write & ack_q;
    assign avs_readdata    = rdata_q;

    // control write needs lane 0, which holds both control bits
    assign ctrl_wr = bus_wr_take & (avs_address == `TRA_OFS_CTRL) & avs_byteenable[0];

    // ack toggles so each request sees exactly one wait cycle
    // and a held request never sees two accepts in a row
    always @(posedge ref_clk) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req & ~ack_q;
        end
    end

    // read data registered in the wait cycle, unmapped reads zero
    // readdata then holds until the next read
    always @(posedge ref_clk) begin
        if (rst) begin
            rdata_q <= 32'h00000000;
        end else if (avs_read && !ack_q) begin
            case (avs_address)
                `TRA_OFS_CTRL: begin
                    rdata_q <= {30'h00000000, en_eval_q, mode_cont_q};
                end
                `TRA_OFS_STATUS: begin
                    rdata_q <= status_word(done_q, rerr_q, div_busy, pend_q);
                end
                `TRA_OFS_AVERAGE: begin
                    rdata_q <= avg_q;
                end
                `TRA_OFS_COUNT: begin
                    rdata_q <= count_q;
                end
                default: begin
                    rdata_q <= 32'h00000000;
                end
            endcase
        end
    end

    // control register: mode and enable evaluation, lane 0 only
    always @(posedge ref_clk) begin
        if (rst) begin
            mode_cont_q <= `TRA_RST_CONT;       // R14
            en_eval_q   <= `TRA_RST_ENEV;
        end else if (ctrl_wr) begin
            mode_cont_q <= avs_writedata[`TRA_CTRL_CONT_BIT];
            en_eval_q   <= avs_writedata[`TRA_CTRL_ENEV_BIT];
        end
    end

    // ----------------------------------------------------------------
    // trigger capture and acceptance
    // ----------------------------------------------------------------
    // enable gates edges only while enable evaluation is on
    assign enabled = ~en_eval_q | enable_in;    // R10

    // the detector remembers a high level through reset, so a
    // trigger already high when reset ends is not an edge
    tra_edge u_edge (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .level_in   (sample_trigger),
        .gate_in    (enabled),
        .rise_pulse (trig_pulse)
    );

    // divider idle: no run in progress and no result about to land
    assign div_idle = ~div_busy & ~div_done;

    // one-time mode refuses triggers as soon as the window is full,
    // not only once the completion flag catches up a cycle later
    assign blocked  = ~mode_cont_q & (done_q | ~filling); // R3
    assign take_now = div_idle & ~blocked & ~clear_request;
    assign go       = take_now & (pend_q | trig_pulse); // R1
    assign x_sel    = pend_q ? pend_val_q : sample_value_in;
    assign filling  = count_q < window_length_in;
    // a zero window divides by one so the divider never sees zero
    assign win_div  = (window_length_in == 32'h00000000) ? 32'h00000001 : window_length_in;

    // one-deep hold for an edge that lands while a division runs
    // a second edge in the same run overwrites the held sample
    always @(posedge ref_clk) begin
        if (rst || clear_request) begin
            pend_q     <= 1'b0;
            pend_val_q <= 32'h00000000;
        end else if (trig_pulse && !blocked && (div_busy || div_done || (pend_q && take_now))) begin
            pend_q     <= 1'b1;
            pend_val_q <= sample_value_in;
        end else if (go) begin
            pend_q     <= 1'b0;
        end else if (blocked) begin
            pend_q     <= 1'b0;             // R3
        end
    end

    // ----------------------------------------------------------------
    // division operands
    // ----------------------------------------------------------------
    // the divider rounds half away from zero and takes 66 cycles;
    // a trigger arriving meanwhile waits in the hold register; the
    // sum is only kept while filling, the recursive step needs none
    always @* begin
        new_sum = sum_q + sext64(x_sel);
        if (filling) begin
            // exact mean of the samples so far
            div_num = new_sum;                  // R4 R8
            div_den = count_q + 32'h00000001;
        end else begin
            // recursive step: (x - avg) / window
            div_num = sext64(x_sel) - sext64(avg_q); // R6 R16
            div_den = win_div;                  // R5
        end
    end

    // clear aborts a running division so a stale result never lands
    tra_div u_div (
        .ref_clk      (ref_clk),
        .rst          (rst),
        .start_in     (go),
        .kill_in      (clear_request),
        .dividend_in  (div_num),
        .divisor_in   (div_den),
        .busy_out     (div_busy),
        .done_pulse   (div_done),
        .quotient_out (div_quot)
    );

    // ----------------------------------------------------------------
    // average state
    // ----------------------------------------------------------------
    // count and average move together on the divider's done pulse while filling, the recursive step moves only the average;
    // the count saturates so it never wraps back to zero
    always @(posedge ref_clk) begin
        if (rst || clear_request) begin
            sum_q     <= 64'h0000000000000000;  // R11
            count_q   <= 32'h00000000;
            avg_q     <= 32'h00000000;
            fill_op_q <= 1'b0;
        end else begin
            if (go) begin
                fill_op_q <= filling;
                if (filling) begin
                    sum_q <= new_sum;
                end
            end
            if (div_done) begin
                if (fill_op_q) begin
                    avg_q <= div_quot;          // R8
                    if (count_q != `TRA_COUNT_MAX) begin
                        count_q <= count_q + 32'h00000001;
                    end
                end else begin
                    avg_q <= avg_q + div_quot;  // R16
                end
            end
        end
    end

    // completion flag: set once count reaches window, then holds;
    // waiting for an idle divider keeps it in step with the count
    always @(posedge ref_clk) begin
        if (rst || clear_request) begin
            done_q <= 1'b0;                     // R11
        end else if (div_idle && !filling) begin
            done_q <= 1'b1;                     // R3 R7
        end
    end

    // a window length with the top bit set lies outside the
    // non-negative range; every 32-bit sample is within range
    assign win_bad = window_length_in[DATA_W-1];

    // range error: registered copy of the window check
    always @(posedge ref_clk) begin
        if (rst) begin
            rerr_q <= 1'b0;
        end else begin
            rerr_q <= win_bad;                  // R13 R15
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // all controller-side outputs come straight from flip-flops
    assign average_out      = avg_q;            // R9
    assign sample_count_out = count_q;          // R9
    assign average_complete = done_q;
    assign range_error      = rerr_q;
endmodule

// [tra_map.vh]
`ifndef TRA_MAP_VH
`define TRA_MAP_VH

// ----------------------------------------------------------------
// register byte offsets (32-bit words)
// ----------------------------------------------------------------
`define TRA_OFS_CTRL        5'h00
`define TRA_OFS_STATUS      5'h04
`define TRA_OFS_AVERAGE     5'h08
`define TRA_OFS_COUNT       5'h0C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TRA_CTRL_CONT_BIT   0
`define TRA_CTRL_ENEV_BIT   1
`define TRA_STAT_DONE_BIT   0
`define TRA_STAT_RERR_BIT   1
`define TRA_STAT_BUSY_BIT   2
`define TRA_STAT_PEND_BIT   3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TRA_RST_CONT        1'b0
`define TRA_RST_ENEV        1'b1

// ----------------------------------------------------------------
// timing counts and count limit
// ----------------------------------------------------------------
`define TRA_DIV_STEPS       7'h42
`define TRA_COUNT_MAX       32'h7FFFFFFF

`endif

// [tra_edge.v]
// ----------------------------------------------------------------
// rising edge detector, gated by the enable condition
// ----------------------------------------------------------------
module tra_edge (
    input  wire ref_clk,
    input  wire rst,
    input  wire level_in,
    input  wire gate_in,
    output wire rise_pulse
);
    reg         prev_q;

    // remember last level so only a 0 to 1 change counts
    always @(posedge ref_clk) begin
        if (rst) begin
            prev_q <= 1'b1;
        end else begin
            prev_q <= level_in;
        end
    end

    assign rise_pulse = level_in & ~prev_q & gate_in;
endmodule

// [tra_div.v]
`include "tra_map.vh"

// ----------------------------------------------------------------
// sequential signed divider, result rounded to nearest
// ----------------------------------------------------------------
module tra_div (
    input  wire               ref_clk,
    input  wire               rst,
    input  wire               start_in,
    input  wire               kill_in,
    input  wire signed [63:0] dividend_in,
    input  wire        [31:0] divisor_in,
    output wire               busy_out,
    output reg                done_pulse,
    output reg  signed [31:0] quotient_out
);
    reg        [65:0] num_q;
    reg        [33:0] rem_q;
    reg        [32:0] den_q;
    reg               neg_q;
    reg               run_q;
    reg        [6:0]  step_q;
    reg        [63:0] mag;
    reg        [33:0] rem_sh;
    reg        [33:0] rem_dif;

    // magnitude of the dividend and one restoring step
    always @* begin
        mag     = dividend_in[63] ? (~dividend_in + 64'h0000000000000001) : dividend_in;
        rem_sh  = {rem_q[32:0], num_q[65]};
        rem_dif = rem_sh - {1'b0, den_q};
    end

    // |a|/d rounded = (2|a| + d) / (2d), one quotient bit per cycle
    always @(posedge ref_clk) begin
        if (rst || kill_in) begin
            num_q        <= 66'h0;
            rem_q        <= 34'h0;
            den_q        <= 33'h0;
            neg_q        <= 1'b0;
            run_q        <= 1'b0;
            step_q       <= 7'h00;
            done_pulse   <= 1'b0;
            quotient_out <= 32'h00000000;
        end else if (start_in && !run_q) begin
            num_q      <= {1'b0, mag, 1'b0} + {34'h0, divisor_in};
            den_q      <= {divisor_in, 1'b0};
            rem_q      <= 34'h0;
            neg_q      <= dividend_in[63];
            run_q      <= 1'b1;
            step_q     <= `TRA_DIV_STEPS;
            done_pulse <= 1'b0;
        end else if (run_q) begin
            if (!rem_dif[33]) begin
                rem_q <= rem_dif;
                num_q <= {num_q[64:0], 1'b1};
            end else begin
                rem_q <= rem_sh;
                num_q <= {num_q[64:0], 1'b0};
            end
            step_q <= step_q - 7'h01;
            if (step_q == 7'h01) begin
                run_q      <= 1'b0;
                done_pulse <= 1'b1;
                if (!rem_dif[33]) begin
                    quotient_out <= neg_q ? -({num_q[30:0], 1'b1}) : {num_q[30:0], 1'b1};
                end else begin
                    quotient_out <= neg_q ? -({num_q[30:0], 1'b0}) : {num_q[30:0], 1'b0};
                end
            end
        end else begin
            done_pulse <= 1'b0;
        end
    end

    assign busy_out = run_q;
endmodule

// [tra_averager_properties.sv]
module tra_averager_properties #(
    parameter DATA_W = 32
) (
    input wire                     ref_clk,
    input wire                     rst,
    input wire                     sample_trigger,
    input wire        [DATA_W-1:0] window_length_in,
    input wire                     enable_in,
    input wire                     clear_request,
    input wire signed [DATA_W-1:0] average_out,
    input wire        [DATA_W-1:0] sample_count_out,
    input wire                     average_complete,
    input wire                     range_error,
    input wire                     avs_read,
    input wire                     avs_write,
    input wire                     avs_waitrequest
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------
    // sequences
    // ------------------------------------------------
    sequence s_wait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    sequence s_take;
        $rose(sample_trigger) && !$past(rst) && enable_in && !clear_request
            && sample_count_out < window_length_in;
    endsequence
    // ------------------------------------------------
    // properties
    // ------------------------------------------------
    property p_wait; $rose(avs_read) || $rose(avs_write) |-> s_wait; endproperty
    property p_idle; !avs_read && !avs_write |-> !avs_waitrequest; endproperty
    property p_clr;
        clear_request |=> sample_count_out == 0 && average_out == 0 && !average_complete;
    endproperty
    property p_rerr; !$past(rst) |-> range_error == $past(window_length_in[DATA_W-1]); endproperty
    property p_step;
        $changed(sample_count_out) && !$past(clear_request)
            |-> sample_count_out == $past(sample_count_out) + 1;
    endproperty
    property p_take; s_take |-> ##[60:75] (sample_count_out == $past(sample_count_out) + 1); endproperty
    property p_hold; average_complete && !clear_request |=> average_complete; endproperty
    property p_cause; average_complete |-> sample_count_out >= window_length_in; endproperty
    property p_set;
        !clear_request && !$past(clear_request) && !window_length_in[DATA_W-1]
            && sample_count_out >= window_length_in |-> ##[0:2] (average_complete || clear_request);
    endproperty
    property p_cap; !window_length_in[DATA_W-1] |-> sample_count_out <= window_length_in; endproperty
    a_wait: assert property (p_wait) else $error("bus wait state wrong");
    a_idle: assert property (p_idle) else $error("waitrequest high while idle");
    a_clr: assert property (p_clr) else $error("clear did not zero outputs");
    a_rerr: assert property (p_rerr) else $error("range flag wrong");
    a_step: assert property (p_step) else $error("count jumped");
    a_take: assert property (p_take) else $error("trigger not taken");
    a_hold: assert property (p_hold) else $error("complete dropped");
    a_cause: assert property (p_cause) else $error("complete too early");
    a_set: assert property (p_set) else $error("complete not set");
    a_cap: assert property (p_cap) else $error("count above window");
endmodule

// [tra_ctrl_model.sv]
// controller logic that drives trigger, sample and window length
module tra_ctrl_model (
    input  wire                ref_clk,
    input  wire                rst,
    input  wire                go,
    input  wire         [31:0] value,
    input  wire         [31:0] n_req,
    output logic               sample_trigger = 1'b0,
    output logic signed [31:0] sample_value_in = 32'h0,
    output logic        [31:0] window_length_in = 32'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    // one-cycle trigger pulse, sample invalid once the pulse ends
    always @(posedge ref_clk) begin
        window_length_in <= n_req;
        if (rst) begin
            sample_trigger <= 1'b0;
        end else if (go) begin
            sample_trigger  <= 1'b1;
            sample_value_in <= value;
        end else begin
            sample_trigger <= 1'b0;
            if (sample_trigger) begin
                sample_value_in <= ~sample_value_in;
            end
        end
    end
endmodule

// [triggered_running_averager_tb.sv]
`include "tra_map.vh"
module triggered_running_averager_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic               ref_clk = 1'b0;
    logic               rst = 1'b1;
    logic               go = 1'b0;
    logic               clear_request = 1'b0;
    logic               enable_in = 1'b1;
    logic        [31:0] value = 32'h0;
    logic        [31:0] n_req = 32'h0;
    logic        [4:0]  avs_address = 5'h00;
    logic               avs_read = 1'b0;
    logic               avs_write = 1'b0;
    logic        [31:0] avs_writedata = 32'h0;
    logic        [3:0]  avs_byteenable = 4'hF;
    logic        [31:0] q;
    wire                sample_trigger;
    wire signed  [31:0] sample_value_in;
    wire signed  [31:0] average_out;
    wire         [31:0] window_length_in;
    wire         [31:0] sample_count_out;
    wire         [31:0] avs_readdata;
    wire                average_complete;
    wire                range_error;
    wire                avs_waitrequest;
    int                 bad_count = 0;
    int                 compares = 0;
    int                 cyc = 0;
    integer             seed = 32'h3CF3D1B2;
    longint             sum, n, nwin, ea;
    // clock and hang guard
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            $display("Error %0t: timeout", $time);
            report_and_stop;
        end
    end
    tra_averager uut (.ref_clk(ref_clk), .rst(rst), .sample_trigger(sample_trigger),
        .sample_value_in(sample_value_in), .window_length_in(window_length_in), .enable_in(enable_in),
        .clear_request(clear_request), .average_out(average_out), .sample_count_out(sample_count_out),
        .average_complete(average_complete), .range_error(range_error), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    tra_ctrl_model u_ctrl (.ref_clk(ref_clk), .rst(rst), .go(go), .value(value), .n_req(n_req),
        .sample_trigger(sample_trigger), .sample_value_in(sample_value_in),
        .window_length_in(window_length_in));
    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    function automatic longint rdiv(longint a, longint b);
        longint m;
        m = ((a < 0 ? -a : a) * 2 + b) / (2 * b);
        return a < 0 ? -m : m;
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] rd);
        @(posedge ref_clk);
        avs_address   <= a;
        avs_write     <= w;
        avs_read      <= ~w;
        avs_writedata <= d;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task smp(input logic [31:0] v, input bit take);
        @(posedge ref_clk);
        go    <= 1'b1;
        value <= v;
        @(posedge ref_clk);
        go <= 1'b0;
        if (take && n < nwin) begin
            sum += $signed(v);
            n++;
            ea = rdiv(sum, n);
        end else if (take) begin
            ea = ea + rdiv(longint'($signed(v)) - ea, nwin);
        end
        repeat (80) @(posedge ref_clk);
        chk(sample_count_out, n[31:0]);
        chk(average_out, ea[31:0]);
        chk({31'h0, average_complete}, {31'h0, n >= nwin});
    endtask
    task clr(input logic [31:0] nv);
        @(posedge ref_clk);
        clear_request <= 1'b1;
        repeat (2) @(posedge ref_clk);
        n_req <= nv;
        chk(sample_count_out, 32'h0);
        chk(average_out, 32'h0);
        chk({31'h0, average_complete}, 32'h0);
        @(posedge ref_clk);
        clear_request <= 1'b0;
        sum  = 0;
        n    = 0;
        ea   = 0;
        nwin = nv;
    endtask
    task report_and_stop;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        bus(1'b0, `TRA_OFS_CTRL, 32'h0, q);
        chk(q, 32'(`TRA_RST_ENEV) << `TRA_CTRL_ENEV_BIT);
        bus(1'b0, 5'h10, 32'h0, q);
        chk(q, 32'h0);
        clr(32'h4);
        smp(32'h7FFFFFFF, 1'b1);
        smp(32'h80000000, 1'b1);
        repeat (2) smp($random(seed) % 1000, 1'b1);
        smp($random(seed) % 1000, 1'b0);
        bus(1'b0, `TRA_OFS_STATUS, 32'h0, q);
        chk({31'h0, q[`TRA_STAT_DONE_BIT]}, 32'h1);
        bus(1'b0, `TRA_OFS_AVERAGE, 32'h0, q);
        chk(q, ea[31:0]);
        bus(1'b1, `TRA_OFS_CTRL, 32'h3, q);
        avs_byteenable <= 4'h0;
        bus(1'b1, `TRA_OFS_CTRL, 32'h0, q);
        avs_byteenable <= 4'hF;
        bus(1'b0, `TRA_OFS_CTRL, 32'h0, q);
        chk(q, 32'h3);
        clr(32'h3);
        repeat (6) smp($random(seed) % 1000, 1'b1);
        enable_in <= 1'b0;
        smp($random(seed) % 1000, 1'b0);
        bus(1'b1, `TRA_OFS_CTRL, 32'h1, q);
        smp($random(seed) % 1000, 1'b1);
        enable_in <= 1'b1;
        clr(32'h80000005);
        bus(1'b0, `TRA_OFS_STATUS, 32'h0, q);
        chk({31'h0, q[`TRA_STAT_RERR_BIT]}, 32'h1);
        chk({31'h0, range_error}, 32'h1);
        clr(32'h5);
        bus(1'b0, `TRA_OFS_COUNT, 32'h0, q);
        chk(q, 32'h0);
        chk({31'h0, range_error}, 32'h0);
        report_and_stop;
    end
endmodule
// checker attached to every averager instance
bind tra_averager tra_averager_properties #(.DATA_W(DATA_W)) u_chk (.ref_clk(ref_clk), .rst(rst),
    .sample_trigger(sample_trigger), .window_length_in(window_length_in), .enable_in(enable_in),
    .clear_request(clear_request), .average_out(average_out), .sample_count_out(sample_count_out),
    .average_complete(average_complete), .range_error(range_error), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));
